// File: shared/abs_enc_pkg.sv
// Purpose: constants for the absolute encoder and battery monitor block
// Assumes: 25 MHz control clock, synchronous active-high reset at power-up
// Notes: times are in milliseconds, cycle counts derived here
package abs_enc_pkg;
   localparam int unsigned CLK_HZ          = 25000000;
   localparam int unsigned VALID_MS        = 5000;
   localparam int unsigned WINDOW_MS       = 4000;
   localparam int unsigned ACQ_MS          = 500;
   localparam int unsigned VALID_CYC       = VALID_MS * (CLK_HZ / 1000);
   localparam int unsigned WINDOW_CYC      = WINDOW_MS * (CLK_HZ / 1000);
   localparam int unsigned ACQ_CYC         = ACQ_MS * (CLK_HZ / 1000);
   localparam int          CNT_W           = 28;
   localparam logic [15:0] TURN_MAX        = 16'h7fff;
   localparam logic [15:0] TURN_MIN        = 16'h8000;
   localparam logic [15:0] TURN_RST        = 16'h0000;
   localparam logic        SEL_ABSOLUTE    = 1'b0;
   localparam logic        SEL_ALARM       = 1'b0;
   // synchroniser reset levels: bit 1 battery present, bit 0 battery low
   localparam logic [1:0]  PIN_IDLE        = 2'h2;
   typedef enum logic [3:0] {
      ST_WAIT  = 4'b0001,
      ST_WIN   = 4'b0010,
      ST_ALWAYS= 4'b0100,
      ST_DONE  = 4'b1000
   } det_state_t;
endpackage

// File: rtl/abs_enc_monitor.sv
// Purpose: multiturn count, battery check and sensor-on gating for a servo drive
// Assumes: CLK 25 MHz, SRST held high while control power is off
// Notes: long times are top parameters so simulation can shorten them
module abs_enc_monitor #(
   parameter int unsigned VALID_CYCLES  = abs_enc_pkg::VALID_CYC,
   parameter int unsigned WINDOW_CYCLES = abs_enc_pkg::WINDOW_CYC,
   parameter int unsigned ACQ_CYCLES    = abs_enc_pkg::ACQ_CYC
) (
   input  wire logic          CLK,
   input  wire logic          SRST,
   input  wire logic          ENCODER_USAGE_SELECT,
   input  wire logic          BATTERY_FAULT_SEVERITY_SELECT,
   input  wire logic          BATTERY_LOW,
   input  wire logic          BATTERY_PRESENT,
   input  wire logic          TURN_FWD,
   input  wire logic          TURN_REV,
   input  wire logic          SENSOR_POWER_ON_CMD,
   input  wire logic          SENSOR_POWER_OFF_CMD,
   input  wire logic          SERVO_ENERGIZE_CMD,
   output logic               ABSOLUTE_MODE,
   output logic signed [15:0] TURN_COUNT,
   output logic               POSITION_LOST,
   output logic               FAULT_OUTPUT_VALID,
   output logic               BATTERY_ALARM,
   output logic               BATTERY_WARNING,
   output logic               SENSOR_ACQUIRING,
   output logic               SENSOR_READY,
   output logic               MOTOR_ENERGIZED
);
   // straps caught after restart, held until next reset
   logic        abs_mode_ff, nxt_abs_mode;
   logic        warn_mode_ff, nxt_warn_mode;
   logic        strap_taken_ff, nxt_strap_taken;
   // three-stage synchronisers for the pins: bit 0 battery low, bit 1 present
   logic [1:0]  pin_raw;
   wire logic [1:0] pin_s;
   logic        bat_low_s, bat_pres_s;
   abs_enc_pkg::det_state_t det_ff, nxt_det;
   logic [abs_enc_pkg::CNT_W-1:0] tmr_ff, nxt_tmr;
   logic        alarm_ff, nxt_alarm;
   logic        warn_ff, nxt_warn;
   logic [15:0] turn_ff, nxt_turn;
   logic        lost_ff, nxt_lost;
   logic        acq_ff, nxt_acq;
   logic        ready_ff, nxt_ready;
   logic [abs_enc_pkg::CNT_W-1:0] acq_tmr_ff, nxt_acq_tmr;
   logic        energ_ff, nxt_energ;
   logic        det_en;
   logic        valid_ff, nxt_valid;

   assign pin_raw = {BATTERY_PRESENT, BATTERY_LOW};

   // a level change counts once stages two and three agree; while they differ
   // the last agreed level is held, so one late-settling sample cannot glitch
   for (genvar g = 0; g < 2; g++) begin : g_pin_sync
      logic [2:0] sync_ff, nxt_sync;
      logic       hold_ff, nxt_hold;
      always_comb begin
         nxt_sync = {sync_ff[1:0], pin_raw[g]};
         nxt_hold = (sync_ff[2] == sync_ff[1]) ? sync_ff[2] : hold_ff;
      end
      always_ff @(posedge CLK) begin
         if (SRST) begin
            sync_ff <= {3{abs_enc_pkg::PIN_IDLE[g]}};
            hold_ff <= abs_enc_pkg::PIN_IDLE[g];
         end else begin
            sync_ff <= nxt_sync;
            hold_ff <= nxt_hold;
         end
      end
      assign pin_s[g] = (sync_ff[2] == sync_ff[1]) ? sync_ff[2] : hold_ff;
   end

   always_comb begin
      bat_low_s  = pin_s[0];
      bat_pres_s = pin_s[1];
   end

   // straps sampled on the first clock after reset; later changes need a restart
   always_comb begin
      nxt_abs_mode    = abs_mode_ff;
      nxt_warn_mode   = warn_mode_ff;
      nxt_strap_taken = 1'b1;
      if (!strap_taken_ff) begin
         nxt_abs_mode  = (ENCODER_USAGE_SELECT == abs_enc_pkg::SEL_ABSOLUTE);
         nxt_warn_mode = (BATTERY_FAULT_SEVERITY_SELECT != abs_enc_pkg::SEL_ALARM);
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         abs_mode_ff    <= 1'b1;
         warn_mode_ff   <= 1'b0;
         strap_taken_ff <= 1'b0;
      end else begin
         abs_mode_ff    <= nxt_abs_mode;
         warn_mode_ff   <= nxt_warn_mode;
         strap_taken_ff <= nxt_strap_taken;
      end
   end

   // detection window; checking is pointless when used as incremental
   always_comb begin
      det_en = abs_mode_ff & strap_taken_ff & ((det_ff == abs_enc_pkg::ST_WIN) |
               (det_ff == abs_enc_pkg::ST_ALWAYS));
      nxt_det   = det_ff;
      nxt_tmr   = tmr_ff + 1'b1;
      nxt_alarm = alarm_ff;
      nxt_warn  = warn_ff;
      case (det_ff)
         abs_enc_pkg::ST_WAIT: begin
            if (tmr_ff >= abs_enc_pkg::CNT_W'(VALID_CYCLES - 1)) begin
               nxt_tmr = '0;
               nxt_det = warn_mode_ff ? abs_enc_pkg::ST_ALWAYS
                                      : abs_enc_pkg::ST_WIN;
            end
         end
         abs_enc_pkg::ST_WIN: begin
            if (tmr_ff >= abs_enc_pkg::CNT_W'(WINDOW_CYCLES - 1)) begin
               nxt_tmr = '0;
               nxt_det = abs_enc_pkg::ST_DONE;
            end
         end
         abs_enc_pkg::ST_ALWAYS: nxt_tmr = '0;
         abs_enc_pkg::ST_DONE:   nxt_tmr = '0;
         default: begin
            nxt_det = abs_enc_pkg::ST_WAIT;
            nxt_tmr = '0;
         end
      endcase
      // alarm latches until reset (power cycle); warning follows the battery
      if (det_en && bat_low_s && !warn_mode_ff) begin
         nxt_alarm = 1'b1;
      end
      nxt_warn = det_en & warn_mode_ff & bat_low_s;
      // registered so the valid pin comes from a flop, in step with the state
      nxt_valid = (nxt_det != abs_enc_pkg::ST_WAIT);
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         det_ff   <= abs_enc_pkg::ST_WAIT;
         tmr_ff   <= '0;
         alarm_ff <= 1'b0;
         warn_ff  <= 1'b0;
         valid_ff <= 1'b0;
      end else begin
         det_ff   <= nxt_det;
         tmr_ff   <= nxt_tmr;
         alarm_ff <= nxt_alarm;
         warn_ff  <= nxt_warn;
         valid_ff <= nxt_valid;
      end
   end

   // multiturn count wraps naturally in 16-bit two's complement
   always_comb begin
      nxt_turn = turn_ff;
      nxt_lost = lost_ff;
      if (TURN_FWD && !TURN_REV) begin
         nxt_turn = (turn_ff == abs_enc_pkg::TURN_MAX) ? abs_enc_pkg::TURN_MIN
                                                       : turn_ff + 16'h0001;
      end else if (TURN_REV && !TURN_FWD) begin
         nxt_turn = (turn_ff == abs_enc_pkg::TURN_MIN) ? abs_enc_pkg::TURN_MAX
                                                       : turn_ff - 16'h0001;
      end
      // battery seen missing while powered marks the data untrustworthy
      if (strap_taken_ff && !bat_pres_s) begin
         nxt_lost = 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         turn_ff <= abs_enc_pkg::TURN_RST;
         lost_ff <= 1'b0;
      end else begin
         turn_ff <= nxt_turn;
         lost_ff <= nxt_lost;
      end
   end

   // sensor-on acquisition; energize held off while it runs
   always_comb begin
      nxt_acq     = acq_ff;
      nxt_ready   = ready_ff;
      nxt_acq_tmr = '0;
      nxt_energ   = energ_ff;
      if (SENSOR_POWER_OFF_CMD) begin
         nxt_acq   = 1'b0;
         nxt_ready = 1'b0;
         nxt_energ = 1'b0;
      end else if (acq_ff) begin
         nxt_acq_tmr = acq_tmr_ff + 1'b1;
         if (acq_tmr_ff >= abs_enc_pkg::CNT_W'(ACQ_CYCLES - 1)) begin
            nxt_acq   = 1'b0;
            nxt_ready = 1'b1;
         end
         nxt_energ = 1'b0;
      end else begin
         if (SENSOR_POWER_ON_CMD && !ready_ff) begin
            nxt_acq   = 1'b1;
            nxt_energ = 1'b0;
         end else begin
            nxt_energ = SERVO_ENERGIZE_CMD & ~alarm_ff;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         acq_ff     <= 1'b0;
         ready_ff   <= 1'b0;
         acq_tmr_ff <= '0;
         energ_ff   <= 1'b0;
      end else begin
         acq_ff     <= nxt_acq;
         ready_ff   <= nxt_ready;
         acq_tmr_ff <= nxt_acq_tmr;
         energ_ff   <= nxt_energ;
      end
   end

   always_comb begin
      ABSOLUTE_MODE      = abs_mode_ff;
      TURN_COUNT         = $signed(turn_ff);
      POSITION_LOST      = lost_ff;
      FAULT_OUTPUT_VALID = valid_ff;
      BATTERY_ALARM      = alarm_ff;
      BATTERY_WARNING    = warn_ff;
      SENSOR_ACQUIRING   = acq_ff;
      SENSOR_READY       = ready_ff;
      MOTOR_ENERGIZED    = energ_ff;
   end

   AST_WRAP_UP: assert property (@(posedge CLK) disable iff (SRST)
      (TURN_FWD && !TURN_REV && turn_ff == 16'h7fff) |=> turn_ff == 16'h8000)
      else $error("forward wrap wrong");
   AST_WRAP_DOWN: assert property (@(posedge CLK) disable iff (SRST)
      (TURN_REV && !TURN_FWD && turn_ff == 16'h8000) |=> turn_ff == 16'h7fff)
      else $error("reverse wrap wrong");
   AST_ALARM_LATCH: assert property (@(posedge CLK) disable iff (SRST)
      alarm_ff |=> alarm_ff)
      else $error("alarm dropped");
   AST_ALARM_AFTER: assert property (@(posedge CLK) disable iff (SRST)
      (det_ff == abs_enc_pkg::ST_DONE && !alarm_ff) |=> !alarm_ff)
      else $error("alarm after window");
   AST_ALARM_SET: assert property (@(posedge CLK) disable iff (SRST)
      (det_ff == abs_enc_pkg::ST_WIN && abs_mode_ff && bat_low_s) |=> alarm_ff)
      else $error("alarm missed");
   AST_WARN: assert property (@(posedge CLK) disable iff (SRST)
      (det_ff == abs_enc_pkg::ST_ALWAYS && abs_mode_ff && bat_low_s) |=> warn_ff && !alarm_ff)
      else $error("warning missed");
   AST_NO_ENERGIZE: assert property (@(posedge CLK) disable iff (SRST)
      acq_ff |=> !energ_ff)
      else $error("energized during acquisition");
   AST_MODE_HOLD: assert property (@(posedge CLK) disable iff (SRST)
      strap_taken_ff |=> $stable(warn_mode_ff) && $stable(abs_mode_ff))
      else $error("mode changed without restart");
   AST_NO_EARLY: assert property (@(posedge CLK) disable iff (SRST)
      (det_ff == abs_enc_pkg::ST_WAIT) |-> !alarm_ff && !warn_ff)
      else $error("fault before valid");
   AST_LOST: assert property (@(posedge CLK) disable iff (SRST)
      (strap_taken_ff && !bat_pres_s) |=> lost_ff)
      else $error("loss not flagged");
   AST_USAGE: assert property (@(posedge CLK) disable iff (SRST)
      (!abs_mode_ff) |-> !alarm_ff && !warn_ff)
      else $error("battery checked in incremental mode");
   // timing of the detection window and of the acquisition interval, plus severity, turn-count and position-loss checks
   AST_VALID_RISE: assert property (@(posedge CLK) disable iff (SRST)
      (det_ff == abs_enc_pkg::ST_WAIT && tmr_ff == abs_enc_pkg::CNT_W'(VALID_CYCLES - 1))
      |=> valid_ff)
      else $error("fault output not valid in time");
   AST_VALID_HOLD: assert property (@(posedge CLK) disable iff (SRST)
      valid_ff |=> valid_ff)
      else $error("fault output valid dropped");
   AST_WIN_CLOSE: assert property (@(posedge CLK) disable iff (SRST)
      (det_ff == abs_enc_pkg::ST_WIN && tmr_ff == abs_enc_pkg::CNT_W'(WINDOW_CYCLES - 1))
      |=> det_ff == abs_enc_pkg::ST_DONE)
      else $error("window did not close");
   AST_DONE_STAYS: assert property (@(posedge CLK) disable iff (SRST)
      (det_ff == abs_enc_pkg::ST_DONE) |=> det_ff == abs_enc_pkg::ST_DONE)
      else $error("window reopened");
   AST_SEV_ALARM: assert property (@(posedge CLK) disable iff (SRST)
      warn_mode_ff |-> !alarm_ff)
      else $error("alarm in warning mode");
   AST_SEV_WARN: assert property (@(posedge CLK) disable iff (SRST)
      !warn_mode_ff |-> !warn_ff)
      else $error("warning in alarm mode");
   AST_WARN_FOLLOW: assert property (@(posedge CLK) disable iff (SRST)
      !bat_low_s |=> !warn_ff)
      else $error("warning without low battery");
   AST_TURN_BOTH: assert property (@(posedge CLK) disable iff (SRST)
      (TURN_FWD && TURN_REV) |=> $stable(turn_ff))
      else $error("count moved on both directions");
   AST_LOST_HOLD: assert property (@(posedge CLK) disable iff (SRST)
      lost_ff |=> lost_ff)
      else $error("position loss cleared");
   AST_ACQ_START: assert property (@(posedge CLK) disable iff (SRST)
      (SENSOR_POWER_ON_CMD && !SENSOR_POWER_OFF_CMD && !acq_ff && !ready_ff)
      |=> acq_ff && !energ_ff)
      else $error("acquisition not started");
   AST_ACQ_END: assert property (@(posedge CLK) disable iff (SRST)
      (acq_ff && acq_tmr_ff >= abs_enc_pkg::CNT_W'(ACQ_CYCLES - 1) && !SENSOR_POWER_OFF_CMD)
      |=> ready_ff && !acq_ff)
      else $error("acquisition did not end");
   AST_READY_HOLD: assert property (@(posedge CLK) disable iff (SRST)
      (ready_ff && !SENSOR_POWER_OFF_CMD) |=> ready_ff)
      else $error("ready dropped without sensor-off");
   AST_SENSOR_OFF: assert property (@(posedge CLK) disable iff (SRST)
      SENSOR_POWER_OFF_CMD |=> !ready_ff && !acq_ff && !energ_ff)
      else $error("sensor-off not obeyed");
endmodule

// File: tb/host_model.sv
// Purpose: host controller stand-in issuing sensor and energize commands
// Assumes: wishes read at the rising edge, commands change at the falling edge
// Notes: tb only says what it wants; sensor on/off edges become single pulses here, energize passes as a level
module host_model (
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic start_on,
   input  wire logic start_off,
   input  wire logic want_energize,
   output logic      on_cmd,
   output logic      off_cmd,
   output logic      energize_cmd
);
   timeunit 1ns;
   timeprecision 1ps;
   logic seen_on_ff    = 1'b0;
   logic seen_off_ff   = 1'b0;
   logic seen_energ_ff = 1'b0;
   logic seen_rst_ff   = 1'b1;
   logic prev_on_ff    = 1'b0;
   logic prev_off_ff   = 1'b0;
   // wishes taken on the rising edge, clear of the tb's falling-edge changes
   always @(posedge clk) begin
      seen_on_ff    <= start_on;
      seen_off_ff   <= start_off;
      seen_energ_ff <= want_energize;
      seen_rst_ff   <= srst;
   end
   always @(negedge clk) begin
      prev_on_ff   <= seen_on_ff;
      prev_off_ff  <= seen_off_ff;
      on_cmd       <= seen_on_ff & ~prev_on_ff;
      off_cmd      <= seen_off_ff & ~prev_off_ff;
      // no energize request while power is down
      energize_cmd <= seen_energ_ff & ~seen_rst_ff;
   end
endmodule

// File: tb/tb.sv
// Purpose: self-checking bench for the encoder and battery monitor
// Assumes: shortened counts 20/40/10 cycles, 25 MHz clock
// Notes: each power-up starts from a clean reset
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLK = 1'b0, SRST = 1'b1, ENCODER_USAGE_SELECT = 1'b0;
   logic BATTERY_FAULT_SEVERITY_SELECT = 1'b0, BATTERY_LOW = 1'b0, BATTERY_PRESENT = 1'b1;
   logic TURN_FWD = 1'b0, TURN_REV = 1'b0, SENSOR_POWER_ON_CMD, SENSOR_POWER_OFF_CMD;
   logic SERVO_ENERGIZE_CMD, ABSOLUTE_MODE, POSITION_LOST, FAULT_OUTPUT_VALID;
   logic BATTERY_ALARM, BATTERY_WARNING, SENSOR_ACQUIRING, SENSOR_READY, MOTOR_ENERGIZED;
   logic signed [15:0] TURN_COUNT;
   logic start_on = 1'b0, start_off = 1'b0, want_energize = 1'b0;
   int errors = 0, n_checks = 0, cycles = 0;
   always #20 CLK = ~CLK;
   host_model host (.clk(CLK), .srst(SRST), .start_on, .start_off, .want_energize,
      .on_cmd(SENSOR_POWER_ON_CMD), .off_cmd(SENSOR_POWER_OFF_CMD),
      .energize_cmd(SERVO_ENERGIZE_CMD));
   abs_enc_monitor #(.VALID_CYCLES(20), .WINDOW_CYCLES(40), .ACQ_CYCLES(10)) uut (
      .CLK, .SRST, .ENCODER_USAGE_SELECT, .BATTERY_FAULT_SEVERITY_SELECT, .BATTERY_LOW,
      .BATTERY_PRESENT, .TURN_FWD, .TURN_REV, .SENSOR_POWER_ON_CMD, .SENSOR_POWER_OFF_CMD,
      .SERVO_ENERGIZE_CMD, .ABSOLUTE_MODE, .TURN_COUNT, .POSITION_LOST, .FAULT_OUTPUT_VALID,
      .BATTERY_ALARM, .BATTERY_WARNING, .SENSOR_ACQUIRING, .SENSOR_READY, .MOTOR_ENERGIZED);
   task automatic complete_run();
      if (errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(negedge CLK);
   endtask
   // sensor-off always precedes the power drop, like a real host
   task automatic power_up(logic usage, logic sev, logic present);
      start_off = 1'b1;
      cyc(2);
      start_off = 1'b0;
      SRST = 1'b1;
      {ENCODER_USAGE_SELECT, BATTERY_FAULT_SEVERITY_SELECT} = {usage, sev};
      {BATTERY_LOW, BATTERY_PRESENT, want_energize, start_on} = {1'b0, present, 2'b00};
      cyc(20);
      SRST = 1'b0;
      cyc(2);
      {ENCODER_USAGE_SELECT, BATTERY_FAULT_SEVERITY_SELECT} = {~usage, ~sev};
   endtask
   task automatic turn_wrap();
      power_up(1'b0, 1'b0, 1'b1);
      chk("count", TURN_COUNT, 16'h0000);
      TURN_REV = 1'b1;
      cyc(32768);
      TURN_REV = 1'b0;
      cyc(1);
      chk("count_min", TURN_COUNT, 16'h8000);
      TURN_REV = 1'b1;
      cyc(1);
      TURN_REV = 1'b0;
      cyc(1);
      chk("count_rev_wrap", TURN_COUNT, 16'h7fff);
      TURN_FWD = 1'b1;
      cyc(1);
      TURN_FWD = 1'b0;
      cyc(1);
      chk("count_fwd_wrap", TURN_COUNT, 16'h8000);
      {TURN_FWD, TURN_REV} = 2'h3;
      cyc(1);
      {TURN_FWD, TURN_REV} = 2'h0;
      cyc(1);
      chk("count_both", TURN_COUNT, 16'h8000);
   endtask
   task automatic alarm_in_window();
      power_up(1'b0, 1'b0, 1'b1);
      chk("absolute", ABSOLUTE_MODE, 1'b1);
      chk("not_valid_yet", FAULT_OUTPUT_VALID, 1'b0);
      cyc(25);
      chk("valid", FAULT_OUTPUT_VALID, 1'b1);
      BATTERY_LOW = 1'b1;
      cyc(6);
      chk("alarm", BATTERY_ALARM, 1'b1);
      chk("warn_in_alarm_mode", BATTERY_WARNING, 1'b0);
      BATTERY_LOW = 1'b0;
      want_energize = 1'b1;
      cyc(8);
      chk("alarm_held", BATTERY_ALARM, 1'b1);
      chk("lost", POSITION_LOST, 1'b0);
      power_up(1'b0, 1'b0, 1'b1);
      chk("alarm_cleared", BATTERY_ALARM, 1'b0);
      // window closed: a late low battery stays silent
      cyc(75);
      BATTERY_LOW = 1'b1;
      cyc(8);
      chk("alarm_late", BATTERY_ALARM, 1'b0);
   endtask
   task automatic warning_mode();
      power_up(1'b0, 1'b1, 1'b1);
      cyc(80);
      BATTERY_LOW = 1'b1;
      cyc(6);
      chk("warning", BATTERY_WARNING, 1'b1);
      chk("no_alarm", BATTERY_ALARM, 1'b0);
      BATTERY_LOW = 1'b0;
      cyc(6);
      chk("warning_off", BATTERY_WARNING, 1'b0);
   endtask
   task automatic sensor_on();
      int n;
      power_up(1'b0, 1'b1, 1'b1);
      start_on = 1'b1;
      cyc(3);
      want_energize = 1'b1;
      cyc(3);
      chk("acquiring", SENSOR_ACQUIRING, 1'b1);
      chk("motor_off", MOTOR_ENERGIZED, 1'b0);
      chk("not_ready", SENSOR_READY, 1'b0);
      n = 0;
      while (SENSOR_READY !== 1'b1 && n < 30) begin
         cyc(1);
         n++;
      end
      cyc(2);
      chk("ready", SENSOR_READY, 1'b1);
      chk("motor_on", MOTOR_ENERGIZED, 1'b1);
      // sensor-off drops readiness; the energize wish is withdrawn with it
      {start_off, want_energize} = 2'h2;
      cyc(3);
      chk("ready_off", SENSOR_READY, 1'b0);
      chk("acquiring_off", SENSOR_ACQUIRING, 1'b0);
      chk("motor_off_again", MOTOR_ENERGIZED, 1'b0);
      start_off = 1'b0;
      cyc(1);
   endtask
   task automatic incremental_and_lost();
      power_up(1'b1, 1'b0, 1'b0);
      chk("incremental", ABSOLUTE_MODE, 1'b0);
      cyc(25);
      BATTERY_LOW = 1'b1;
      cyc(8);
      chk("alarm_incr", BATTERY_ALARM, 1'b0);
      chk("lost", POSITION_LOST, 1'b1);
   endtask
   // enough for the long wrap run plus every power cycle
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 40000) begin
         errors++;
         complete_run();
      end
   end
   initial begin
      turn_wrap();
      alarm_in_window();
      warning_mode();
      sensor_on();
      incremental_and_lost();
      complete_run();
   end
endmodule
